/* spgm_gpio_mux.sv */
// Shared-pin GPIO multiplexer with APB register access
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - A mux bit of 1 routes the pin to its peripheral, 0 to GPIO.
// - In GPIO mode a direction bit of 0 makes an input, 1 an output driven from data; port D pins 1-7 never drive.
// - Reading data of an input pin in GPIO mode gives the pin level, except port D pins 1-7; writing an output sets its level.
// - Data and direction bits affect the pin only while GPIO is selected.
// - Each port register keeps data in bits 0-7 and direction in bits 8-15.
// - Mux A bits 0-7 serve port A, 8-15 port B; mux B 0-7 port C, 8-15 port D.
// - Mux bits reset to 0 except mux B bits 0, 1 and 9-15, which reset to 1.
// - Pin control sits in 16-bit mux and port data/direction registers, plus a fixed mask that keeps port D pins 1-7 from GPIO drive.
module spgm_gpio_mux
  import spgm_pkg::*;
(
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [SPGM_ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic [31:0] PIN_IN,
  output logic [31:0] PIN_OUT,
  output logic [31:0] PIN_OE_OUT,
  input wire logic [31:0] PERIPH_OUT_IN,
  input wire logic [31:0] PERIPH_OE_IN,
  output logic [31:0] PERIPH_IN_OUT
);

  typedef enum logic [2:0] {
    SPGM_R_MUXA = 3'b000,
    SPGM_R_MUXB = 3'b001,
    SPGM_R_PA = 3'b010,
    SPGM_R_PB = 3'b011,
    SPGM_R_PC = 3'b100,
    SPGM_R_PD = 3'b101,
    SPGM_R_NONE = 3'b111
  } spgm_reg_e;

  logic [15:0] pin_mux_select_a;
  logic [15:0] pin_mux_select_b;
  logic [15:0] port_data_direction [SPGM_PORTS];
  logic [31:0] mux_all;
  logic [31:0] dir_all;
  logic [31:0] dat_all;
  logic [31:0] gpio_ok;
  logic [15:0] wdata;
  logic wr_en;
  spgm_reg_e sel;

  function automatic spgm_reg_e decode(input logic [SPGM_ADDR_W-1:0] a);
    case (a)
      SPGM_OFS_MUX_A: decode = SPGM_R_MUXA;
      SPGM_OFS_MUX_B: decode = SPGM_R_MUXB;
      SPGM_OFS_PORT_A: decode = SPGM_R_PA;
      SPGM_OFS_PORT_B: decode = SPGM_R_PB;
      SPGM_OFS_PORT_C: decode = SPGM_R_PC;
      SPGM_OFS_PORT_D: decode = SPGM_R_PD;
      default: decode = SPGM_R_NONE;
    endcase
  endfunction : decode

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] nw, input logic [1:0] strb);
    merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
  endfunction : merge

  assign sel = decode(PADDR_IN);
  assign wdata = PWDATA_IN[15:0];
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && (sel == SPGM_R_NONE);

  // Mux registers, 16 bits each
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pin_mux_select_a <= SPGM_RST_MUX_A;
      pin_mux_select_b <= SPGM_RST_MUX_B;
    end else if (wr_en) begin
      if (sel == SPGM_R_MUXA) begin
        pin_mux_select_a <= merge(pin_mux_select_a, wdata, PSTRB_IN[1:0]);
      end
      if (sel == SPGM_R_MUXB) begin
        pin_mux_select_b <= merge(pin_mux_select_b, wdata, PSTRB_IN[1:0]);
      end
    end
  end

  // Port data/direction registers; bits change only on bus writes, port_rd supplies input pin levels
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      for (int p = 0; p < SPGM_PORTS; p++) begin
        port_data_direction[p] <= SPGM_RST_PORT;
      end
    end else begin
      for (int p = 0; p < SPGM_PORTS; p++) begin
        if (wr_en && sel == spgm_reg_e'(3'(p + SPGM_PORT_FIRST))) begin
          port_data_direction[p] <= merge(port_data_direction[p], wdata,
              PSTRB_IN[1:0]);
        end
      end
    end
  end

  // Flatten fields: pin index = port*8 + bit
  always_comb begin
    mux_all = {pin_mux_select_b, pin_mux_select_a};
    for (int p = 0; p < SPGM_PORTS; p++) begin
      dat_all[p*SPGM_PINS +: SPGM_PINS] =
          port_data_direction[p][0 +: SPGM_PINS];
      dir_all[p*SPGM_PINS +: SPGM_PINS] =
          port_data_direction[p][SPGM_DIR_LSB +: SPGM_PINS];
    end
    gpio_ok = SPGM_GPIO_MASK;
  end

  // Pad drive and peripheral routing
  always_comb begin
    for (int i = 0; i < SPGM_PIN_TOTAL; i++) begin
      if (mux_all[i]) begin
        PIN_OUT[i] = PERIPH_OUT_IN[i];
        PIN_OE_OUT[i] = PERIPH_OE_IN[i];
      end else begin
        PIN_OUT[i] = dat_all[i] && gpio_ok[i];
        PIN_OE_OUT[i] = dir_all[i] && gpio_ok[i];
      end
      PERIPH_IN_OUT[i] = mux_all[i] ? PIN_IN[i] : 1'b0;
    end
  end

  // Read data: input pins in GPIO mode, except port D pins 1-7, show the pin level
  always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      PRDATA_OUT <= 32'h00000000;
    end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      case (sel)
        SPGM_R_MUXA: PRDATA_OUT <= {16'h0000, pin_mux_select_a};
        SPGM_R_MUXB: PRDATA_OUT <= {16'h0000, pin_mux_select_b};
        SPGM_R_PA, SPGM_R_PB, SPGM_R_PC, SPGM_R_PD: begin
          PRDATA_OUT <= {16'h0000,
              port_rd(3'(sel) - 3'(SPGM_PORT_FIRST))};
        end
        default: PRDATA_OUT <= 32'h00000000;
      endcase
    end
  end

  function automatic logic [15:0] port_rd(input logic [2:0] p);
    logic [15:0] r;
    logic [7:0] pin8;
    logic [7:0] gp8;
    logic [7:0] md8;
    r = port_data_direction[p[1:0]];
    pin8 = PIN_IN[p[1:0]*SPGM_PINS +: SPGM_PINS];
    gp8 = gpio_ok[p[1:0]*SPGM_PINS +: SPGM_PINS];
    md8 = mux_all[p[1:0]*SPGM_PINS +: SPGM_PINS];
    for (int b = 0; b < SPGM_PINS; b++) begin
      if (!md8[b] && !r[SPGM_DIR_LSB+b] && gp8[b]) begin
        r[b] = pin8[b];
      end
    end
    port_rd = r;
  endfunction : port_rd

  // Bus phases the checks are built from
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence

  sequence s_rd_pin1_in;
    PSEL_IN && !PENABLE_IN && !PWRITE_IN && sel == SPGM_R_PA &&
        !mux_all[1] && !dir_all[1];
  endsequence

  sequence s_rd_mux_b;
    PSEL_IN && !PENABLE_IN && !PWRITE_IN && sel == SPGM_R_MUXB;
  endsequence

  sequence s_wr_port_a;
    wr_en && sel == SPGM_R_PA && PSTRB_IN == SPGM_STRB_ALL;
  endsequence

  sequence s_wr_port_b_low;
    wr_en && sel == SPGM_R_PB && !PSTRB_IN[1];
  endsequence

  sequence s_wr_mux_b;
    wr_en && sel == SPGM_R_MUXB && PSTRB_IN == SPGM_STRB_ALL;
  endsequence

  sequence s_wr_unmapped;
    wr_en && sel == SPGM_R_NONE;
  endsequence

  a_mux_reset: assert property (
      @(posedge CLOCK_IN) $rose(RSTN_IN) |->
      pin_mux_select_a == SPGM_RST_MUX_A &&
      pin_mux_select_b == SPGM_RST_MUX_B)
    else $error("mux reset value wrong");

  a_reset_idle: assert property (
      @(posedge CLOCK_IN) $rose(RSTN_IN) |->
      (PIN_OE_OUT & ~mux_all) == 32'h00000000)
    else $error("gpio pin driven after reset");

  a_periph_route: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      mux_all[0] |-> PIN_OUT[0] == PERIPH_OUT_IN[0])
    else $error("peripheral not routed");

  a_periph_input: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      mux_all[17] |-> PERIPH_IN_OUT[17] == PIN_IN[17])
    else $error("pin level not passed to peripheral");

  a_periph_gated: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !mux_all[16] |-> !PERIPH_IN_OUT[16])
    else $error("gpio pin leaks to peripheral");

  a_gpio_drive: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !mux_all[3] && dir_all[3] |->
      PIN_OE_OUT[3] && PIN_OUT[3] == port_data_direction[0][3])
    else $error("gpio output not driven");

  a_gpio_input: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !mux_all[16] && !dir_all[16] |-> !PIN_OE_OUT[16])
    else $error("gpio input driven");

  a_out_level: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !mux_all[5] && dir_all[5] |-> PIN_OUT[5] == dat_all[5])
    else $error("output level differs from data bit");

  a_port_read: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_rd_pin1_in ##1 s_access |-> PRDATA_OUT[1] == $past(PIN_IN[1]))
    else $error("input level not read");

  a_port_write: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_wr_port_a |=> dat_all[7:0] == $past(PWDATA_IN[7:0]))
    else $error("data field not written");

  a_rdata_hold: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_access |=> $stable(PRDATA_OUT))
    else $error("read data changed after access");

  a_mux_isolate: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      mux_all[4] |-> PIN_OE_OUT[4] == PERIPH_OE_IN[4] &&
      PIN_OUT[4] == PERIPH_OUT_IN[4])
    else $error("port bits leak to pin");

  a_dir_field: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_wr_port_a |=> dir_all[7:0] == $past(PWDATA_IN[15:8]))
    else $error("direction field misplaced");

  a_lane_keep: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_wr_port_b_low |=> dir_all[15:8] == $past(dir_all[15:8]))
    else $error("unselected lane written");

  a_mux_write: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_wr_mux_b |=> mux_all[31:16] == $past(PWDATA_IN[15:0]))
    else $error("mux b write lost");

  a_mux_b_read: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_rd_mux_b |=> PRDATA_OUT[15:0] == $past(pin_mux_select_b))
    else $error("mux b read wrong");

  a_bus_ready: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_access |-> PREADY_OUT)
    else $error("access phase not ready");

  a_bus_error: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_access |-> PSLVERR_OUT == (sel == SPGM_R_NONE))
    else $error("bus error flag wrong");

  a_unmapped_wr: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      s_wr_unmapped |=> mux_all == $past(mux_all) &&
      dir_all == $past(dir_all) &&
      dat_all == $past(dat_all))
    else $error("unmapped write changed state");

  a_portd_dead: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      PIN_OE_OUT[31:25] == (mux_all[31:25] & PERIPH_OE_IN[31:25]))
    else $error("port d reserved pin driven");

  a_portd_gpio: assert property (
      @(posedge CLOCK_IN) disable iff (!RSTN_IN)
      !mux_all[24] && dir_all[24] |-> PIN_OE_OUT[24])
    else $error("port d pin 0 not driven");

endmodule : spgm_gpio_mux
`default_nettype wire

/* spgm_pkg.sv */
// Package for the shared-pin GPIO multiplexer: register map and reset values
package spgm_pkg;
  localparam int SPGM_ADDR_W = 12;
  localparam logic [11:0] SPGM_OFS_MUX_A = 12'h000;
  localparam logic [11:0] SPGM_OFS_MUX_B = 12'h004;
  localparam logic [11:0] SPGM_OFS_PORT_A = 12'h008;
  localparam logic [11:0] SPGM_OFS_PORT_B = 12'h00c;
  localparam logic [11:0] SPGM_OFS_PORT_C = 12'h010;
  localparam logic [11:0] SPGM_OFS_PORT_D = 12'h014;
  localparam logic [15:0] SPGM_RST_MUX_A = 16'h0000;
  localparam logic [15:0] SPGM_RST_MUX_B = 16'hfe03;
  localparam logic [15:0] SPGM_RST_PORT = 16'h0000;
  localparam int SPGM_PINS = 8;
  localparam int SPGM_DIR_LSB = 8;
  localparam logic [7:0] SPGM_PORT_D_GPIO = 8'h01;
  localparam int SPGM_PORTS = 4;
  localparam int SPGM_PIN_TOTAL = 32;
  localparam int SPGM_PORT_FIRST = 2;
  localparam logic [31:0] SPGM_GPIO_MASK = {SPGM_PORT_D_GPIO, 24'hff_ffff};
  localparam logic [3:0] SPGM_STRB_ALL = 4'hf;
endpackage : spgm_pkg

/* spgm_pad_model.sv */
// Pad model for the shared-pin multiplexer bench
`timescale 1ns/10ps
`default_nettype none
module spgm_pad_model (
  input wire logic [31:0] drive_in,
  input wire logic [31:0] drive_oe_in,
  input wire logic [31:0] ext_in,
  output logic [31:0] level_out
);
  // Pad shows the device drive, else the outside level
  assign level_out = (drive_oe_in & drive_in) | (~drive_oe_in & ext_in);
endmodule : spgm_pad_model
`default_nettype wire

/* tb_shared_pin_gpio_mux.sv */
// Self-checking bench for the shared-pin GPIO multiplexer
`timescale 1ns/10ps
`default_nettype none
module tb_shared_pin_gpio_mux;
  import spgm_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, ready, slverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, pin_out, pin_oe, level, per_in, r;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] ext = 32'h5ac3_3ca5;
  logic [31:0] per_out = 32'h3c3c_3c3c, per_oe = 32'h0f0f_0f0f;
  logic [15:0] sh [6] = '{16'h0000, 16'hfe03, 0, 0, 0, 0};
  int errors = 0, n_compared = 0;
  always #2 clk = ~clk;
  spgm_pad_model pad (.drive_in(pin_out), .drive_oe_in(pin_oe),
    .ext_in(ext), .level_out(level));
  spgm_gpio_mux dut (.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata),
    .PREADY_OUT(ready), .PSLVERR_OUT(slverr), .PIN_IN(level),
    .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .PERIPH_OUT_IN(per_out),
    .PERIPH_OE_IN(per_oe), .PERIPH_IN_OUT(per_in));
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (ready !== 1'b1);
    rd = prdata;
    er = slverr;
    psel <= 0;
    pen <= 0;
  endtask : xfer
  task wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    xfer(1'b1, a, {16'h0000, d}, s, r, e);
    chk("write_err", {31'h0, e}, {31'h0, a >= 12'h018});
    if (a < 12'h018 && s[0]) sh[a>>2][7:0] = d[7:0];
    if (a < 12'h018 && s[1]) sh[a>>2][15:8] = d[15:8];
  endtask : wr
  task check_all;
    logic [31:0] mx, dr, dt, gm, oe, va, x;
    @(negedge clk);
    mx = {sh[1], sh[0]};
    for (int i = 0; i < 32; i++) begin
      dr[i] = sh[2+i/8][8+i%8];
      dt[i] = sh[2+i/8][i%8];
    end
    gm = ~mx & 32'h01ff_ffff;
    oe = (gm & dr) | (mx & per_oe);
    va = (gm & dt) | (mx & per_out);
    chk("pin_oe", pin_oe, oe);
    chk("pin_out", pin_out & oe, va & oe);
    chk("periph_in", per_in, mx & ((oe & va) | (~oe & ext)));
    for (int p = 0; p < 6; p++) begin
      x = {16'h0000, sh[p]};
      for (int i = 0; i < 8; i++)
        if (p > 1 && gm[(p-2)*8+i] && !dr[(p-2)*8+i]) x[i] = ext[(p-2)*8+i];
      xfer(1'b0, 12'(p*4), 32'h0, 4'h0, r, e);
      chk("register", r, x);
      chk("read_err", {31'h0, e}, 32'h0);
    end
  endtask : check_all
  initial begin
    #20000;
    errors++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    check_all;
    wr(SPGM_OFS_MUX_B, 16'hfe02, 4'hf);
    wr(SPGM_OFS_MUX_A, 16'h00f0, 4'hf);
    wr(SPGM_OFS_PORT_A, 16'hffa5, 4'hf);
    wr(SPGM_OFS_PORT_B, 16'hffff, 4'h1);
    wr(SPGM_OFS_PORT_C, 16'h0f33, 4'hf);
    wr(SPGM_OFS_PORT_D, 16'hff5a, 4'hf);
    check_all;
    wr(SPGM_OFS_MUX_A, 16'hf00f, 4'hf);
    wr(SPGM_OFS_MUX_B, 16'hff01, 4'hf);
    per_oe <= 32'hf0f0_f00f;
    check_all;
    xfer(1'b0, 12'h018, 32'h0, 4'h0, r, e);
    chk("unmapped_data", r, 32'h0);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    wr(12'h018, 16'h1234, 4'hf);
    check_all;
    test_done;
  end
endmodule : tb_shared_pin_gpio_mux
`default_nettype wire
